/* File: include/sadc_pkg.sv */
// Package: constants for the serial converter control block
package sadc_pkg;
   // Conversion result width and channel address width
   localparam int RES_W = 10;
   localparam int ADDR_W = 4;
   // Self-test channel address and its fixed code (mid band)
   localparam logic [3:0] SELF_TEST_CHANNEL = 4'hb;
   localparam logic [9:0] SELF_TEST_CODE = 10'h200;
   localparam logic [9:0] SELF_TEST_MIN = 10'h1f4;
   localparam logic [9:0] SELF_TEST_MAX = 10'h20c;
   localparam logic [9:0] CODE_ALL_ONES = 10'h3ff;
   localparam logic [9:0] CODE_ALL_ZEROS = 10'h000;
   // Chip-select recognition delay and conversion length, system clock cycles
   localparam int CS_SETUP_CYC = 3;
   localparam int CONV_CYC = 44;
   // Falling I/O clock edges: sampling starts after 4, hold and convert at 10
   localparam int ADDR_BITS_IN = 4;
   localparam int LAST_FALL = 10;
   // Limits in nanoseconds and derived core clock counts
   localparam int CORE_PERIOD_NS = 40;
   localparam int CONV_MAX_NS = 21000;
   localparam int CONV_MAX_CYC = CONV_MAX_NS / CORE_PERIOD_NS;
   localparam int CYCLE_MIN_NS = 31000;
   localparam int CYCLE_MIN_CYC = (CYCLE_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   // System clock enable divider: 25 MHz down to about 2.3 MHz
   // Eleven, not twelve: 44 system clocks of 12 core cycles would overrun 21 us
   localparam int SYS_DIV = 11;
   localparam int FIFO_DEPTH = 8;
   // Reset values
   localparam logic [9:0] RESULT_RST = 10'h000;
   localparam logic [3:0] ADDR_RST = 4'h0;
endpackage

/* File: rtl/result_fifo.sv */
// Module: small synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module result_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data = mem[rd_ptr_ff];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* File: rtl/sadc_ctrl.sv */
// Module: control logic of a 10-bit serial successive-approximation converter
//
// Summary of operation
// - Ignore controls three system clocks after select
// - Address 1011 converts internal self-test level
// - Out-of-range inputs clamp to all ones/zeros
// - Convert within 21 us, cycle 31 us
// - Sample selected channel six I/O clock cycles
// - Four control inputs, one three-state data output
// - System and I/O clocks fully independent
// - System clock alone drives the conversion
// - Address in MSB first, rising edges one-four
// - Previous MSB on select, rest on falls
// - Tenth fall starts 44-clock conversion unless result buffer full
// - Select high: output off, inputs ignored
`timescale 1ns/100ps
module sadc_ctrl (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic CS_B,
   input wire logic ADDR_IN,
   input wire logic IO_CLK,
   input wire logic [10:0][9:0] CH_CODE,
   input wire logic [10:0] CH_OVER,
   input wire logic [10:0] CH_UNDER,
   output logic DATA_OUT,
   output logic DATA_OE,
   output logic SAMPLING,
   output logic [3:0] SAMPLE_CH,
   output logic CONV_BUSY,
   output logic RES_VALID,
   input wire logic RES_READY,
   output logic [9:0] RES_DATA
);
   // ****************************************************
   // Input synchronisers and system clock enable
   // ****************************************************
   logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
   logic ad_s1_ff, ad_s2_ff;
   logic io_s1_ff, io_s2_ff, io_s3_ff;
   logic [3:0] div_ff;
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         {cs_s1_ff, cs_s2_ff, cs_s3_ff} <= 3'h7;
         {ad_s1_ff, ad_s2_ff} <= 2'h0;
         {io_s1_ff, io_s2_ff, io_s3_ff} <= 3'h0;
         div_ff <= 4'h0;
      end else begin
         cs_s1_ff <= CS_B;
         cs_s2_ff <= cs_s1_ff;
         cs_s3_ff <= cs_s2_ff;
         ad_s1_ff <= ADDR_IN;
         ad_s2_ff <= ad_s1_ff;
         io_s1_ff <= IO_CLK;
         io_s2_ff <= io_s1_ff;
         io_s3_ff <= io_s2_ff;
         div_ff <= (div_ff == 4'(sadc_pkg::SYS_DIV - 1)) ? 4'h0 : div_ff + 4'h1;
      end
   end
   // io clock edges found by the core clock, no relation to system clock
   wire sys_en = (div_ff == 4'h0);
   wire cs_fall = cs_s3_ff && !cs_s2_ff;
   wire io_rise = io_s2_ff && !io_s3_ff;
   wire io_fall = !io_s2_ff && io_s3_ff;

   // ****************************************************
   // Access sequencing
   // ****************************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_XFER = 4'b0100,
      ST_DONE = 4'b1000
   } acc_t;
   acc_t acc_ff, nxt_acc;
   logic [1:0] setup_ff;
   logic [3:0] rise_cnt_ff;
   logic [3:0] fall_cnt_ff;
   logic [3:0] addr_sh_ff;
   logic [9:0] out_sh_ff;
   logic [9:0] result_ff;
   logic [3:0] samp_ch_ff;
   logic samp_ff;
   logic conv_ff;
   logic [5:0] conv_cnt_ff;
   logic [9:0] conv_code_ff;
   logic data_out_ff;
   logic conv_done;
   logic fifo_ready;

   // select high always returns to idle
   wire cs_high = cs_s2_ff;
   wire setup_done = (setup_ff == 2'(sadc_pkg::CS_SETUP_CYC - 1)) && sys_en;
   wire in_xfer = (acc_ff == ST_XFER) && !cs_high;
   wire take_bit = in_xfer && io_rise && (rise_cnt_ff < 4'(sadc_pkg::ADDR_BITS_IN));
   wire last_fall = in_xfer && io_fall && (fall_cnt_ff == 4'(sadc_pkg::LAST_FALL - 1));
   // a full fifo drops the conversion that the tenth fall would start
   wire start_conv = last_fall && fifo_ready;

   always_comb begin
      nxt_acc = acc_ff;
      case (acc_ff)
         ST_IDLE: begin
            if (cs_fall) begin
               nxt_acc = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (cs_high) begin
               nxt_acc = ST_IDLE;
            end else if (setup_done) begin
               nxt_acc = ST_XFER;
            end
         end
         ST_XFER: begin
            if (cs_high) begin
               nxt_acc = ST_IDLE;
            end else if (last_fall) begin
               nxt_acc = ST_DONE;
            end
         end
         ST_DONE: begin
            if (cs_high) begin
               nxt_acc = ST_IDLE;
            end else if (!conv_ff) begin
               nxt_acc = ST_XFER;
            end
         end
         default: begin
            nxt_acc = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         acc_ff <= ST_IDLE;
         setup_ff <= 2'h0;
      end else begin
         acc_ff <= nxt_acc;
         // wait three system clocks before honouring controls
         if (acc_ff != ST_WAIT) begin
            setup_ff <= 2'h0;
         end else if (sys_en) begin
            setup_ff <= setup_ff + 2'h1;
         end
      end
   end

   // ****************************************************
   // Address in, result out
   // ****************************************************
   wire load_out = (acc_ff != ST_XFER) && (nxt_acc == ST_XFER);
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         rise_cnt_ff <= 4'h0;
         fall_cnt_ff <= 4'h0;
         addr_sh_ff <= sadc_pkg::ADDR_RST;
         out_sh_ff <= sadc_pkg::RESULT_RST;
         data_out_ff <= 1'b0;
      end else if (load_out) begin
         // previous result MSB presented once select is recognised
         rise_cnt_ff <= 4'h0;
         fall_cnt_ff <= 4'h0;
         out_sh_ff <= {result_ff[8:0], 1'b0};
         data_out_ff <= result_ff[9];
      end else begin
         // address shifted in MSB first on first four rises
         if (take_bit) begin
            addr_sh_ff <= {addr_sh_ff[2:0], ad_s2_ff};
            rise_cnt_ff <= rise_cnt_ff + 4'h1;
         end
         if (in_xfer && io_fall) begin
            fall_cnt_ff <= fall_cnt_ff + 4'h1;
            // remaining nine bits on following falling edges
            data_out_ff <= out_sh_ff[9];
            out_sh_ff <= {out_sh_ff[8:0], 1'b0};
         end
      end
   end

   // ****************************************************
   // Sample and conversion engine
   // ****************************************************
   // self-test channel gives a fixed mid-scale code
   wire is_test = (samp_ch_ff == sadc_pkg::SELF_TEST_CHANNEL);
   wire ch_ok = (samp_ch_ff < sadc_pkg::SELF_TEST_CHANNEL);
   wire [9:0] raw_code = ch_ok ? CH_CODE[samp_ch_ff] : sadc_pkg::CODE_ALL_ZEROS;
   wire over = ch_ok && CH_OVER[samp_ch_ff];
   wire under = ch_ok && CH_UNDER[samp_ch_ff];
   // clamp rather than wrap outside the references
   wire [9:0] code_sel = is_test ? sadc_pkg::SELF_TEST_CODE :
                         over ? sadc_pkg::CODE_ALL_ONES :
                         under ? sadc_pkg::CODE_ALL_ZEROS : raw_code;
   // 44 system clocks of 11 core cycles stay under the 21 us bound
   assign conv_done = conv_ff && sys_en &&
                      (conv_cnt_ff == 6'(sadc_pkg::CONV_CYC - 1));

   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         samp_ff <= 1'b0;
         samp_ch_ff <= sadc_pkg::ADDR_RST;
         conv_ff <= 1'b0;
         conv_cnt_ff <= 6'h0;
         conv_code_ff <= sadc_pkg::RESULT_RST;
         result_ff <= sadc_pkg::RESULT_RST;
      end else begin
         // sample from fourth fall through tenth fall
         if (in_xfer && io_fall && fall_cnt_ff == 4'(sadc_pkg::ADDR_BITS_IN - 1)) begin
            samp_ff <= 1'b1;
            samp_ch_ff <= addr_sh_ff;
         end else if (last_fall || cs_fall) begin
            // Tenth fall ends sampling even when a full buffer refuses the conversion
            samp_ff <= 1'b0;
         end
         // hold at tenth fall, then 44 system clocks
         if (start_conv) begin
            conv_ff <= 1'b1;
            conv_cnt_ff <= 6'h0;
            conv_code_ff <= code_sel;
         end else if (cs_fall && conv_ff) begin
            // A new select edge aborts the conversion, old result kept
            conv_ff <= 1'b0;
         end else if (conv_done) begin
            conv_ff <= 1'b0;
            // result held until the next conversion completes
            result_ff <= conv_code_ff;
         end else if (conv_ff && sys_en) begin
            // engine advances only on the system clock
            conv_cnt_ff <= conv_cnt_ff + 6'h1;
         end
      end
   end

   // ****************************************************
   // Result stream buffer and outputs
   // ****************************************************
   result_fifo #(
      .WIDTH(sadc_pkg::RES_W),
      .DEPTH(sadc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .in_valid(conv_done),
      .in_ready(fifo_ready),
      .in_data(conv_code_ff),
      .out_valid(RES_VALID),
      .out_ready(RES_READY),
      .out_data(RES_DATA)
   );

   assign DATA_OUT = data_out_ff;
   // output disabled while select is high
   assign DATA_OE = (acc_ff == ST_XFER || acc_ff == ST_DONE) && !cs_high;
   assign SAMPLING = samp_ff;
   assign SAMPLE_CH = samp_ch_ff;
   assign CONV_BUSY = conv_ff;
endmodule

/* File: tb/sadc_ctrl_assertions.sv */
// Checker for the serial converter control block
`timescale 1ns/100ps
module sadc_ctrl_assertions (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic CS_B,
   input wire logic DATA_OE,
   input wire logic SAMPLING,
   input wire logic [3:0] SAMPLE_CH,
   input wire logic CONV_BUSY,
   input wire logic RES_VALID,
   input wire logic RES_READY,
   input wire logic [9:0] RES_DATA
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   // Phase lengths, cleared while the phase is idle
   logic [9:0] busy_ff;
   logic [9:0] samp_ff;
   always_ff @(posedge CORE_CLK) begin
      busy_ff <= CONV_BUSY ? busy_ff + 10'h001 : 10'h000;
      samp_ff <= SAMPLING ? samp_ff + 10'h001 : 10'h000;
   end
   sequence cs_fall_idle;
      $fell(CS_B) && !DATA_OE;
   endsequence
   sequence cs_held_low;
      !CS_B [*8];
   endsequence
   AST_OE_OFF: assert property (CS_B [*6] |-> !DATA_OE)
      else $error("data enabled while deselected");
   AST_CS_SETUP: assert property (cs_fall_idle |-> !DATA_OE [*8])
      else $error("select answered too early");
   AST_OE_ON: assert property (cs_fall_idle ##1 cs_held_low |-> ##[0:40] (DATA_OE || CS_B))
      else $error("no data after select");
   AST_CONV_LEN: assert property ($fell(CONV_BUSY) |-> busy_ff > 10'((sadc_pkg::CONV_CYC - 1) * sadc_pkg::SYS_DIV) && busy_ff <= 10'(sadc_pkg::CONV_CYC * sadc_pkg::SYS_DIV))
      else $error("conversion length wrong");
   AST_CONV_TIME: assert property ($fell(CONV_BUSY) |-> busy_ff <= 10'(sadc_pkg::CONV_MAX_CYC))
      else $error("conversion slower than allowed");
   AST_CONV_START: assert property ($rose(CONV_BUSY) |-> $past(SAMPLING))
      else $error("conversion without sampling");
   AST_SAMPLE_LEN: assert property ($fell(SAMPLING) |-> samp_ff >= 10'h02e && samp_ff <= 10'h032)
      else $error("sampling length wrong");
   AST_CH_STABLE: assert property (SAMPLING && $past(SAMPLING) |-> $stable(SAMPLE_CH))
      else $error("channel moved while sampling");
   AST_DONE_RESULT: assert property ($fell(CONV_BUSY) |-> ##[0:2] RES_VALID)
      else $error("no result after conversion");
   AST_FIFO_HOLD: assert property (RES_VALID && !RES_READY |=> RES_VALID && $stable(RES_DATA))
      else $error("result head changed unread");
endmodule
bind sadc_ctrl sadc_ctrl_assertions chk (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .CS_B(CS_B),
   .DATA_OE(DATA_OE), .SAMPLING(SAMPLING), .SAMPLE_CH(SAMPLE_CH), .CONV_BUSY(CONV_BUSY),
   .RES_VALID(RES_VALID), .RES_READY(RES_READY), .RES_DATA(RES_DATA));

/* File: tb/sadc_host_model.sv */
// Controller model driving the converter's serial control pins
`timescale 1ns/100ps
module sadc_host_model (
   output logic cs_b,
   output logic addr_in,
   output logic io_clk,
   input wire logic data_out,
   input wire logic data_oe
);
   initial begin
      cs_b = 1'b1;
      addr_in = 1'b0;
      io_clk = 1'b0;
   end
   // ****************************************
   // One access; the I/O clock stands low between frames
   // ****************************************
   task automatic xfer(input logic [3:0] addr, input int setup_ns, output logic [9:0] rd);
      cs_b = 1'b0;
      #(setup_ns);
      for (int k = 0; k < 10; k++) begin
         addr_in = (k < 4) ? addr[3 - k] : ~addr_in;
         #160 io_clk = 1'b1;
         #150 rd[9 - k] = data_oe ? data_out : 1'bx;
         #10 io_clk = 1'b0;
      end
      #160 cs_b = 1'b1;
      addr_in = ~addr_in;
      #25000;
   endtask
endmodule

/* File: tb/sadc_ctrl_tb_top.sv */
// Self-checking bench for the serial converter control block
`timescale 1ns/100ps
module sadc_ctrl_tb_top;
   logic core_clk, rst_b, cs_b, addr_in, io_clk, data_out, data_oe;
   logic sampling, conv_busy, res_valid, res_ready;
   logic [3:0] sample_ch;
   logic [9:0] res_data;
   logic [10:0][9:0] ch_code;
   logic [10:0] ch_over, ch_under;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   sadc_ctrl dut (.CORE_CLK(core_clk), .RST_B(rst_b), .CS_B(cs_b), .ADDR_IN(addr_in),
      .IO_CLK(io_clk), .CH_CODE(ch_code), .CH_OVER(ch_over), .CH_UNDER(ch_under),
      .DATA_OUT(data_out), .DATA_OE(data_oe), .SAMPLING(sampling), .SAMPLE_CH(sample_ch),
      .CONV_BUSY(conv_busy), .RES_VALID(res_valid), .RES_READY(res_ready),
      .RES_DATA(res_data));
   sadc_host_model host (.cs_b(cs_b), .addr_in(addr_in), .io_clk(io_clk),
      .data_out(data_out), .data_oe(data_oe));
   // ****************************************
   // Clock, timeout and reporting
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      if (fail_count == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // ****************************************
   // Shared steps
   // ****************************************
   task automatic pop(input logic [9:0] exp);
      @(negedge core_clk);
      check({9'h000, res_valid}, 10'h001);
      check(res_data, exp);
      res_ready = 1'b1;
      @(negedge core_clk);
      res_ready = 1'b0;
   endtask
   // Reads the previous result while converting the named channel
   task automatic convert(input logic [3:0] ch, input logic [9:0] prev, input logic [9:0] exp);
      logic [9:0] rd;
      host.xfer(ch, 2000 + 32'(ch) * 160, rd);
      check(rd, prev);
      check({6'h00, sample_ch}, {6'h00, ch});
      pop(exp);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_channels;
      convert(4'h0, sadc_pkg::RESULT_RST, ch_code[0]);
      for (int i = 1; i < 11; i++) begin
         convert(4'(i), ch_code[i - 1], ch_code[i]);
      end
   endtask
   task automatic test_self_and_clamp;
      convert(sadc_pkg::SELF_TEST_CHANNEL, ch_code[10], sadc_pkg::SELF_TEST_CODE);
      ch_over[5] = 1'b1;
      convert(4'h5, sadc_pkg::SELF_TEST_CODE, sadc_pkg::CODE_ALL_ONES);
      ch_under[5] = 1'b1;
      convert(4'h5, sadc_pkg::CODE_ALL_ONES, sadc_pkg::CODE_ALL_ONES);
      ch_over[5] = 1'b0;
      convert(4'h5, sadc_pkg::CODE_ALL_ONES, sadc_pkg::CODE_ALL_ZEROS);
      ch_under[5] = 1'b0;
   endtask
   // A full buffer refuses the next conversion, so the old result stays
   task automatic test_fill;
      logic [9:0] rd;
      ch_code[2] = 10'h155;
      for (int i = 0; i < 9; i++) begin
         if (i == 8) ch_code[2] = 10'h0aa;
         host.xfer(4'h2, 2000, rd);
      end
      host.xfer(4'h2, 2000, rd);
      check(rd, 10'h155);
      for (int i = 0; i < 8; i++) pop(10'h155);
      check({9'h000, res_valid}, 10'h000);
   endtask
   initial begin
      rst_b = 1'b0;
      res_ready = 1'b0;
      ch_over = 11'h000;
      ch_under = 11'h000;
      for (int i = 0; i < 11; i++) ch_code[i] = 10'(i) * 10'h05d + 10'h007;
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge core_clk);
      test_channels();
      test_self_and_clamp();
      test_fill();
      report_and_stop();
   end
endmodule
